// *** rtl/gsr_map.svh ***
// register offsets, field positions, reset values and widths of the routing block
// assumes a 32-bit bus with byte addresses and one aligned word per register
`ifndef GSR_MAP_SVH
`define GSR_MAP_SVH
`define GSR_PAD_CFG_BASE   12'h000
`define GSR_IN_CFG_BASE    12'h400
`define GSR_GPIO_OUT_ADDR  12'h800
`define GSR_PAD_LEVEL_ADDR 12'h804
`define GSR_DIRECT_ADDR    12'h808
`define GSR_REGION_MSB     11
`define GSR_REGION_LSB     10
`define GSR_FUNC_LSB       0
`define GSR_FUNC_MSB       2
`define GSR_DRIVE_LSB      4
`define GSR_DRIVE_MSB      5
`define GSR_IE_BIT         7
`define GSR_MSEL_LSB       8
`define GSR_MSEL_MSB       15
`define GSR_FUNC_RESET     3'h1
`define GSR_DRIVE_RESET    2'h2
`define GSR_IE_RESET       1'b1
`define GSR_ISRC_LSB       0
`define GSR_ISRC_MSB       7
`define GSR_IINV_BIT       8
`define GSR_IROUTE_BIT     9
`define GSR_PAD_CFG_W      16
`define GSR_IN_CFG_W       10
`endif

// *** rtl/gsr_pkg.sv ***
// types shared by the routing block
// assumes gsr_map.svh supplies the numeric layout
package gsr_pkg;
   typedef logic [1:0] gsr_drive_t;
   typedef logic [7:0] gsr_sig_t;
   typedef enum logic [2:0] {
      GSR_FN_OFF    = 3'h0,
      GSR_FN_DIRECT = 3'h1,
      GSR_FN_MATRIX = 3'h2,
      GSR_FN_GPIO   = 3'h3
   } gsr_func_e;
endpackage : gsr_pkg

// *** rtl/gsr_pad_sync.sv ***
// three-stage synchroniser for pad levels
// assumes pads change asynchronously to clock; output moves only when stages 2 and 3 agree
module gsr_pad_sync import gsr_pkg::*; #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] level
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] level_r;
   logic [W-1:0] level_nxt;

   always_comb begin
      for (int i = 0; i < W; i++) begin
         level_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : level_r[i];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         s1_r    <= '0;
         s2_r    <= '0;
         s3_r    <= '0;
         level_r <= '0;
      end else begin
         s1_r    <= async_in;
         s2_r    <= s1_r;
         s3_r    <= s2_r;
         level_r <= level_nxt;
      end
   end

   assign level = level_r;
endmodule : gsr_pad_sync

// *** rtl/gsr_matrix.sv ***
// pad function multiplexer and signal routing matrix with an AHB-Lite register slave
// assumes peripherals sit on clock; pads are asynchronous and are synchronised here
//
// Chosen here: the register offsets and the AHB-Lite interface to the registers.
`include "gsr_map.svh"
module gsr_matrix import gsr_pkg::*; #(
   parameter int          NPAD       = 8,
   parameter int          NSIG       = 16,
   parameter logic [15:0] HAS_DIRECT = 16'h3fff,
   parameter logic [15:0] PLAIN_IN   = 16'h0000,
   parameter logic [15:0] HIGH_IN    = 16'h0000,
   parameter logic [15:0] OE_CONST   = 16'hc000,
   parameter logic [15:0] DEF_LEVEL  = 16'h0000
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              hsel,
   input  wire logic [31:0]       haddr,
   input  wire logic [1:0]        htrans,
   input  wire logic              hwrite,
   input  wire logic [2:0]        hsize,
   input  wire logic [31:0]       hwdata,
   input  wire logic              hready,
   output logic                   hreadyout,
   output logic [31:0]            hrdata,
   output logic                   hresp,
   input  wire logic [NSIG-1:0]   periph_out,
   input  wire logic [NSIG-1:0]   periph_oe,
   output logic      [NSIG-1:0]   periph_in,
   input  wire logic [NPAD-1:0]   pad_in,
   output logic      [NPAD-1:0]   pad_out,
   output logic      [NPAD-1:0]   pad_oe,
   output logic      [NPAD-1:0]   pad_input_enable,
   output logic      [2*NPAD-1:0] pad_drive
);
   logic [`GSR_PAD_CFG_W-1:0] pad_cfg_r   [NPAD];
   logic [`GSR_PAD_CFG_W-1:0] pad_cfg_nxt [NPAD];
   logic [`GSR_IN_CFG_W-1:0]  in_cfg_r    [NSIG];
   logic [`GSR_IN_CFG_W-1:0]  in_cfg_nxt  [NSIG];
   logic [2*NPAD-1:0]         gpio_r;
   logic [2*NPAD-1:0]         gpio_nxt;
   logic [11:0]               addr_r;
   logic [11:0]               addr_nxt;
   logic                      wr_r;
   logic                      wr_nxt;
   logic [31:0]               hrdata_r;
   logic [31:0]               hrdata_nxt;
   logic                      acc;
   logic [NPAD-1:0]           pad_lvl;
   logic [NPAD-1:0]           pad_out_r;
   logic [NPAD-1:0]           pad_out_nxt;
   logic [NPAD-1:0]           pad_oe_r;
   logic [NPAD-1:0]           pad_oe_nxt;
   logic [NSIG-1:0]           pin_r;
   logic [NSIG-1:0]           pin_nxt;

   // region codes of the two configuration arrays
   localparam logic [11:0] PAD_BASE = `GSR_PAD_CFG_BASE;
   localparam logic [11:0] IN_BASE  = `GSR_IN_CFG_BASE;

   gsr_pad_sync #(
      .W (NPAD)
   ) u_sync (
      .clock    (clock),
      .rst_n    (rst_n),
      .async_in (pad_in),
      .level    (pad_lvl)
   );

   // register file: address phase captured, write lands in the data phase
   always_comb begin
      logic [7:0] widx;
      logic [7:0] ridx;
      widx     = addr_r[9:2];
      ridx     = haddr[9:2];
      acc      = hsel & htrans[1] & hready;
      wr_nxt   = acc & hwrite;
      addr_nxt = acc ? haddr[11:0] : addr_r;
      gpio_nxt = gpio_r;
      for (int p = 0; p < NPAD; p++) begin
         pad_cfg_nxt[p] = pad_cfg_r[p];
      end
      for (int s = 0; s < NSIG; s++) begin
         in_cfg_nxt[s] = in_cfg_r[s];
      end
      if (wr_r) begin
         if (addr_r[`GSR_REGION_MSB:`GSR_REGION_LSB] == PAD_BASE[11:10]) begin
            for (int p = 0; p < NPAD; p++) begin
               if (widx == 8'(p)) begin
                  pad_cfg_nxt[p] = hwdata[`GSR_PAD_CFG_W-1:0];
               end
            end
         end else if (addr_r[`GSR_REGION_MSB:`GSR_REGION_LSB] == IN_BASE[11:10]) begin
            for (int s = 0; s < NSIG; s++) begin
               if (widx == 8'(s)) begin
                  in_cfg_nxt[s] = hwdata[`GSR_IN_CFG_W-1:0];
               end
            end
         end else if (addr_r == `GSR_GPIO_OUT_ADDR) begin
            gpio_nxt = hwdata[2*NPAD-1:0];
         end
      end
      // read mux looks at next values so a read right after a write sees it
      hrdata_nxt = hrdata_r;
      if (acc && !hwrite) begin
         hrdata_nxt = 32'h0;
         if (haddr[`GSR_REGION_MSB:`GSR_REGION_LSB] == PAD_BASE[11:10]) begin
            for (int p = 0; p < NPAD; p++) begin
               if (ridx == 8'(p)) begin
                  hrdata_nxt[`GSR_PAD_CFG_W-1:0] = pad_cfg_nxt[p];
               end
            end
         end else if (haddr[`GSR_REGION_MSB:`GSR_REGION_LSB] == IN_BASE[11:10]) begin
            for (int s = 0; s < NSIG; s++) begin
               if (ridx == 8'(s)) begin
                  hrdata_nxt[`GSR_IN_CFG_W-1:0] = in_cfg_nxt[s];
               end
            end
         end else if (haddr[11:0] == `GSR_GPIO_OUT_ADDR) begin
            hrdata_nxt[2*NPAD-1:0] = gpio_nxt;
         end else if (haddr[11:0] == `GSR_PAD_LEVEL_ADDR) begin
            hrdata_nxt[NPAD-1:0] = pad_lvl;
         end else if (haddr[11:0] == `GSR_DIRECT_ADDR) begin
            hrdata_nxt[NSIG-1:0] = HAS_DIRECT[NSIG-1:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         for (int p = 0; p < NPAD; p++) begin
            pad_cfg_r[p] <= '0;
            pad_cfg_r[p][`GSR_FUNC_MSB:`GSR_FUNC_LSB] <= `GSR_FUNC_RESET;
            pad_cfg_r[p][`GSR_DRIVE_MSB:`GSR_DRIVE_LSB] <= `GSR_DRIVE_RESET;
            pad_cfg_r[p][`GSR_IE_BIT] <= `GSR_IE_RESET;
         end
         for (int s = 0; s < NSIG; s++) begin
            in_cfg_r[s] <= '0;
         end
         gpio_r   <= '0;
         addr_r   <= 12'h0;
         wr_r     <= 1'b0;
         hrdata_r <= 32'h0;
      end else begin
         for (int p = 0; p < NPAD; p++) begin
            pad_cfg_r[p] <= pad_cfg_nxt[p];
         end
         for (int s = 0; s < NSIG; s++) begin
            in_cfg_r[s] <= in_cfg_nxt[s];
         end
         gpio_r   <= gpio_nxt;
         addr_r   <= addr_nxt;
         wr_r     <= wr_nxt;
         hrdata_r <= hrdata_nxt;
      end
   end

   // pad side: direct function, matrix or software level per pad
   always_comb begin
      logic [7:0] msel;
      logic [2:0] fsel;
      msel = 8'h00;
      fsel = 3'h0;
      for (int p = 0; p < NPAD; p++) begin
         pad_out_nxt[p] = 1'b0;
         pad_oe_nxt[p]  = 1'b0;
         msel = pad_cfg_r[p][`GSR_MSEL_MSB:`GSR_MSEL_LSB];
         fsel = pad_cfg_r[p][`GSR_FUNC_MSB:`GSR_FUNC_LSB];
         case (fsel)
            GSR_FN_DIRECT: begin
               if (p < NSIG) begin
                  pad_out_nxt[p] = periph_out[p];
                  pad_oe_nxt[p]  = OE_CONST[p] | periph_oe[p];
               end
            end
            GSR_FN_MATRIX: begin
               for (int s = 0; s < NSIG; s++) begin
                  if (msel == 8'(s)) begin
                     pad_out_nxt[p] = periph_out[s];
                     pad_oe_nxt[p]  = OE_CONST[s] | periph_oe[s];
                  end
               end
            end
            GSR_FN_GPIO: begin
               pad_out_nxt[p] = gpio_r[p];
               pad_oe_nxt[p]  = gpio_r[NPAD+p];
            end
            default: begin
               pad_oe_nxt[p] = 1'b0;
            end
         endcase
      end
   end

   // peripheral side: matrix route, then direct path, then default level
   always_comb begin
      logic [7:0] src;
      logic       inv;
      logic       direct_sel;
      src        = 8'h00;
      inv        = 1'b0;
      direct_sel = 1'b0;
      for (int s = 0; s < NSIG; s++) begin
         src = in_cfg_r[s][`GSR_ISRC_MSB:`GSR_ISRC_LSB];
         inv = in_cfg_r[s][`GSR_IINV_BIT];
         direct_sel = 1'b0;
         if (s < NPAD) begin
            direct_sel = pad_cfg_r[s][`GSR_FUNC_MSB:`GSR_FUNC_LSB] == GSR_FN_DIRECT;
         end
         pin_nxt[s] = DEF_LEVEL[s] ^ inv;
         if (in_cfg_r[s][`GSR_IROUTE_BIT] && src < 8'(NPAD)) begin
            for (int p = 0; p < NPAD; p++) begin
               if (src == 8'(p)) begin
                  pin_nxt[s] = pad_lvl[p] ^ inv;
               end
            end
         end else if (HAS_DIRECT[s] && s < NPAD) begin
            if (PLAIN_IN[s] || direct_sel) begin
               pin_nxt[s] = pad_lvl[s];
            end else if (HIGH_IN[s]) begin
               pin_nxt[s] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pad_out_r <= '0;
         pad_oe_r  <= '0;
         pin_r     <= '0;
      end else begin
         pad_out_r <= pad_out_nxt;
         pad_oe_r  <= pad_oe_nxt;
         pin_r     <= pin_nxt;
      end
   end

   always_comb begin
      for (int p = 0; p < NPAD; p++) begin
         pad_input_enable[p]  = pad_cfg_r[p][`GSR_IE_BIT];
         pad_drive[2*p +: 2]  = pad_cfg_r[p][`GSR_DRIVE_MSB:`GSR_DRIVE_LSB];
      end
   end

   assign pad_out   = pad_out_r;
   assign pad_oe    = pad_oe_r;
   assign periph_in = pin_r;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;
endmodule : gsr_matrix

// *** tb/gsr_far_model.sv ***
// far side: peripheral drivers and external pad drivers
// assumes the bench chooses the levels the far side drives
module gsr_far_model (
   input  wire logic [7:0]  pad_out,
   input  wire logic [7:0]  pad_oe,
   input  wire logic [7:0]  ext_lvl,
   input  wire logic [15:0] po_set,
   input  wire logic [15:0] pe_set,
   output logic      [15:0] periph_out,
   output logic      [15:0] periph_oe,
   output logic      [7:0]  pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   // the block's pad driver wins over the external party
   assign pad_in     = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
   assign periph_out = po_set;
   assign periph_oe  = pe_set;
endmodule : gsr_far_model

// *** tb/gsr_matrix_chk.sv ***
// port checker for the routing block
// assumes it is bound onto gsr_matrix with 8 pads and 16 signals
module gsr_matrix_chk #(
   parameter logic [15:0] HAS_DIRECT = 16'h0000
) (
   input wire logic        clock,
   input wire logic        rst_n,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic        hresp,
   input wire logic [15:0] periph_out,
   input wire logic [15:0] periph_oe,
   input wire logic [7:0]  pad_out,
   input wire logic [7:0]  pad_oe,
   input wire logic [7:0]  pad_input_enable,
   input wire logic [15:0] pad_drive
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock); endclocking
   wire take = hsel && htrans[1] && hready;
   sequence s_rel;
      !rst_n ##1 rst_n;
   endsequence
   sequence s_rd_dir;
      take && !hwrite && haddr[11:0] == 12'h808;
   endsequence
   sequence s_wr_p0;
      take && hwrite && haddr[11:0] == 12'h000 ##1 1'b1;
   endsequence
   AST_OE_RST: assert property (!rst_n |=> pad_oe == 8'h00)
      else $error("pad driven in reset");
   AST_IE_RST: assert property (!rst_n |=> pad_input_enable == 8'hff)
      else $error("input enable not set in reset");
   AST_DRV_RST: assert property (!rst_n |=> pad_drive == 16'haaaa)
      else $error("drive code not 2 in reset");
   AST_FN1_OUT: assert property (s_rel |=> pad_out == $past(periph_out[7:0]))
      else $error("pad out not function 1");
   AST_FN1_OE: assert property (s_rel |=> pad_oe == $past(periph_oe[7:0]))
      else $error("pad oe not function 1");
   AST_DIRECT: assert property (disable iff (!rst_n) s_rd_dir |=> hrdata == {16'h0000, HAS_DIRECT})
      else $error("direct flags wrong");
   AST_DRV: assert property (disable iff (!rst_n) s_wr_p0 |=> pad_drive[1:0] == $past(hwdata[5:4]))
      else $error("drive code not taken");
   AST_OK: assert property (hreadyout && !hresp)
      else $error("bus not ready or error");
endmodule : gsr_matrix_chk
bind gsr_matrix gsr_matrix_chk #(.HAS_DIRECT(HAS_DIRECT)) u_chk (.*);

// *** tb/gsr_matrix_test.sv ***
// self-checking bench for the routing block
// assumes gsr_matrix, gsr_far_model and the bound checker
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin fail_count++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module gsr_matrix_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] HD = 16'h3fff;
   localparam logic [15:0] OEC = 16'hc000;
   logic        clock = '0, rst_n = '0, hsel = '0, hwrite = '0, hreadyout, hresp;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0]  htrans = '0;
   logic [2:0]  hsize = 3'h2;
   logic [15:0] po = '0, pe = '0, periph_out, periph_oe, periph_in, pad_drive;
   logic [15:0] lf = 16'h0008;
   logic [7:0]  ext = '0, pad_in, pad_out, pad_oe, pad_input_enable;
   logic [3:0]  s;
   int          fail_count = 0, check_count = 0, i;
   always #20 clock = ~clock;
   gsr_matrix #(.NPAD(8), .NSIG(16), .HAS_DIRECT(HD), .PLAIN_IN(16'h0008),
      .HIGH_IN(16'h0010), .OE_CONST(OEC), .DEF_LEVEL(16'h0000)) DUT (
      .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready(hreadyout), .hreadyout, .hrdata, .hresp, .periph_out, .periph_oe,
      .periph_in, .pad_in, .pad_out, .pad_oe, .pad_input_enable, .pad_drive);
   gsr_far_model FAR (.pad_out, .pad_oe, .ext_lvl(ext), .po_set(po), .pe_set(pe),
      .periph_out, .periph_oe, .pad_in);
   function automatic logic [15:0] nx(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nx
   function automatic logic exp_in(logic lvl, logic inv);
      return lvl ^ inv;
   endfunction : exp_in
   task automatic summarize();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : summarize
   task automatic waitrdy();
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         summarize();
      end
   endtask : waitrdy
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock);
      hsel <= 1'b1;
      haddr <= {20'h00000, a};
      hwrite <= w;
      htrans <= 2'h2;
      waitrdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitrdy();
      rd = hrdata;
      hsel <= 1'b0;
   endtask : xfer
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   initial begin
      tick(10);
      `CHK("oe_rst", 8'h00, pad_oe)
      `CHK("drv_rst", 16'haaaa, pad_drive)
      @(posedge clock);
      rst_n <= 1'b1;
      po <= nx(lf);
      pe <= ~nx(lf);
      tick(2);
      `CHK("fn1_out", po[7:0], pad_out)
      `CHK("fn1_oe", pe[7:0] | OEC[7:0], pad_oe)
      $display("test reset done");
      xfer(1'b1, 12'h808, 32'h00000000);
      xfer(1'b0, 12'h808, 32'h00000000);
      `CHK("direct", {16'h0000, HD}, rd)
      xfer(1'b0, 12'hc00, 32'h00000000);
      `CHK("unmapped", 32'h00000000, rd)
      for (i = 0; i < 4; i++) begin
         xfer(1'b1, 12'h000, 32'h00000081 | 32'(i << 4));
         tick(2);
         `CHK("drive", 2'(i), pad_drive[1:0])
      end
      $display("test registers done");
      for (i = 0; i < 6; i++) begin
         lf = nx(lf);
         s = (i == 0) ? 4'he : (i == 1) ? 4'hf : lf[3:0];
         @(posedge clock);
         po <= lf;
         pe <= lf & 16'h3fff;
         xfer(1'b1, 12'h004, {20'h00000, s, 8'h82});
         tick(2);
         `CHK("mx_out", po[s], pad_out[1])
         `CHK("mx_oe", pe[s] | OEC[s], pad_oe[1])
      end
      $display("test matrix out done");
      xfer(1'b1, 12'h008, 32'h00000080);
      for (i = 0; i < 4; i++) begin
         lf = nx(lf);
         @(posedge clock);
         ext <= lf[7:0];
         xfer(1'b1, 12'h424, {22'h000000, 1'b1, i[0], 8'h02});
         tick(8);
         `CHK("mx_in", exp_in(lf[2], i[0]), periph_in[9])
         xfer(1'b1, 12'h424, {22'h000000, 1'b1, i[0], 8'h08});
         tick(2);
         `CHK("def_in", exp_in(1'b0, i[0]), periph_in[9])
      end
      $display("test matrix in done");
      xfer(1'b1, 12'h00c, 32'h00000080);
      xfer(1'b1, 12'h010, 32'h00000080);
      @(posedge clock);
      ext <= ~ext;
      tick(8);
      `CHK("plain_in", ext[3], periph_in[3])
      `CHK("high_in", 1'b1, periph_in[4])
      @(posedge clock);
      ext <= ~ext;
      tick(8);
      `CHK("plain_in2", ext[3], periph_in[3])
      `CHK("high_in2", 1'b1, periph_in[4])
      $display("test unselected inputs done");
      lf = nx(lf);
      xfer(1'b1, 12'h800, {16'h0000, 8'h20, lf[7:0]});
      xfer(1'b1, 12'h014, 32'h00000083);
      xfer(1'b1, 12'h018, 32'h00000001);
      tick(8);
      `CHK("gpio_out", lf[5], pad_out[5])
      `CHK("gpio_oe", 1'b1, pad_oe[5])
      `CHK("ie_off", 1'b0, pad_input_enable[6])
      xfer(1'b0, 12'h800, 32'h00000000);
      `CHK("gpio_rd", {16'h0000, 8'h20, lf[7:0]}, rd)
      xfer(1'b0, 12'h804, 32'h00000000);
      `CHK("pad_lvl", lf[5], rd[5])
      $display("test software pads done");
      summarize();
   end
endmodule : gsr_matrix_test
